// file: include/dsr_consts.vh
// Constants for the drive status and I/O readback block
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH
// =========================================
// Register offsets (word indices)
`define DSR_STATE_A_OFS 12'h0C8
`define DSR_INPUT_A_OFS 12'h0C9
`define DSR_STATE_B_OFS 12'h4B0
`define DSR_INPUT_B_OFS 12'h4B1
// =========================================
// Drive state word bit positions
`define DSR_ST_FLD_ON 4
`define DSR_ST_FLD_IDC 5
`define DSR_ST_FLD_LIM 6
`define DSR_ST_FLT 8
`define DSR_ST_WRN 9
`define DSR_ST_PH_ORD 10
`define DSR_ST_LINE_PHASE_READY 11
`define DSR_ST_SYNC 14
`define DSR_ST_OS 15
// =========================================
// I/O word bit positions
`define DSR_IO_RUN 0
`define DSR_IO_CONT 1
`define DSR_IO_AUX2 2
`define DSR_IO_AUX3 3
`define DSR_IO_AUX4 4
`define DSR_IO_AUX5 5
`define DSR_IO_GAN 6
`define DSR_IO_BAL 7
`define DSR_IO_STR 8
`define DSR_IO_LVL 9
// =========================================
// Drive control bit positions
`define DSR_CT_FLD_RUN 4
`define DSR_CT_FLD_ID 5
`define DSR_CT_CAL_EN 6
`define DSR_CT_FLT_RST 8
`define DSR_CT_WRN_RST 9
// =========================================
// Reset values and sync loss count
`define DSR_RESET_WORD 16'h0000
`define DSR_SYNC_LOSS_MAX 2'h2
`endif

// file: hw/dsr_readback.v
// Drive status and I/O readback registers for two drive channels
`include "dsr_consts.vh"

module dsr_readback #(
    parameter CH = 2
) (
    clock,
    rstn,
    clk_en,
    scan_strobe,
    global_stop,
    field_reg_active,
    field_ident_done,
    field_loop_limited,
    fault_event,
    warning_event,
    drive_ctrl_flat,
    line_phase_order,
    line_phase_ready,
    sync_enabled,
    sync_miss,
    sync_match,
    os_download_done,
    run_permit_input,
    contactor_feedback,
    aux_input_two,
    aux_input_three,
    aux_input_four,
    aux_input_five,
    resolver_gain_done,
    resolver_balance_done,
    motor_turning,
    ext_strobe,
    resolver_pos_flat,
    rd_en,
    rd_addr,
    rd_data,
    rd_valid,
    strobe_pos_flat
);
    input wire clock;
    input wire rstn;
    input wire clk_en;
    input wire scan_strobe;
    input wire global_stop;
    input wire [CH-1:0] field_reg_active;
    input wire [CH-1:0] field_ident_done;
    input wire [CH-1:0] field_loop_limited;
    input wire [CH-1:0] fault_event;
    input wire [CH-1:0] warning_event;
    input wire [16*CH-1:0] drive_ctrl_flat;
    input wire [CH-1:0] line_phase_order;
    input wire [CH-1:0] line_phase_ready;
    input wire sync_enabled;
    input wire [CH-1:0] sync_miss;
    input wire [CH-1:0] sync_match;
    input wire [CH-1:0] os_download_done;
    input wire [CH-1:0] run_permit_input;
    input wire [CH-1:0] contactor_feedback;
    input wire [CH-1:0] aux_input_two;
    input wire [CH-1:0] aux_input_three;
    input wire [CH-1:0] aux_input_four;
    input wire [CH-1:0] aux_input_five;
    input wire [CH-1:0] resolver_gain_done;
    input wire [CH-1:0] resolver_balance_done;
    input wire [CH-1:0] motor_turning;
    input wire [CH-1:0] ext_strobe;
    input wire [16*CH-1:0] resolver_pos_flat;
    input wire rd_en;
    input wire [11:0] rd_addr;
    output reg [15:0] rd_data;
    output reg rd_valid;
    output reg [16*CH-1:0] strobe_pos_flat;

    // =========================================
    // Pin synchroniser: 9 pin-level inputs per channel
    localparam PN = 9;
    reg [PN*CH-1:0] pin_s1_reg;
    reg [PN*CH-1:0] pin_s2_reg;
    wire [PN*CH-1:0] pin_raw;
    reg [CH-1:0] strb_prev_reg;
    reg [16*CH-1:0] st_word_reg;
    reg [16*CH-1:0] io_word_reg;
    reg [16*CH-1:0] st_word_next;
    reg [16*CH-1:0] io_word_next;
    reg [CH-1:0] flt_sticky_reg;
    reg [CH-1:0] wrn_sticky_reg;
    reg [CH-1:0] ident_reg;
    reg [CH-1:0] gain_reg;
    reg [CH-1:0] bal_reg;
    reg [CH-1:0] strobe_edge_polarity_reg;
    reg [CH-1:0] str_pend_reg;
    reg [2*CH-1:0] miss_cnt_reg;
    reg [CH-1:0] lock_reg;

    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : g_pin
            assign pin_raw[PN*g+PN-1:PN*g] = {ext_strobe[g], motor_turning[g],
                run_permit_input[g], contactor_feedback[g], aux_input_two[g],
                aux_input_three[g], aux_input_four[g], aux_input_five[g],
                sync_miss[g]};
        end
    endgenerate

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_s1_reg <= {PN*CH{1'b0}};
            pin_s2_reg <= {PN*CH{1'b0}};
        end else if (clk_en) begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // =========================================
    // Channel field pickers
    // Pick one synchronised pin bit of a channel
    function pin_bit;
        input [PN*CH-1:0] v;
        input integer ch;
        input integer idx;
        begin
            pin_bit = v[PN*ch+idx];
        end
    endfunction

    // Pick one drive control bit of a channel
    function ctl_bit;
        input [16*CH-1:0] v;
        input integer ch;
        input integer pos;
        begin
            ctl_bit = v[16*ch+pos];
        end
    endfunction

    // =========================================
    // Event latches; set wins over clear on the same cycle, except ident, where DSR_CT_FLD_ID low clears ahead of a set
    integer i;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flt_sticky_reg <= {CH{1'b0}};
            wrn_sticky_reg <= {CH{1'b0}};
            ident_reg <= {CH{1'b0}};
            gain_reg <= {CH{1'b0}};
            bal_reg <= {CH{1'b0}};
        end else if (clk_en) begin
            for (i = 0; i < CH; i = i + 1) begin
                // Cause stays latched while it persists, even through a reset
                if (fault_event[i])
                    flt_sticky_reg[i] <= 1'b1;
                else if (ctl_bit(drive_ctrl_flat, i, `DSR_CT_FLT_RST))
                    flt_sticky_reg[i] <= 1'b0;
                if (warning_event[i])
                    wrn_sticky_reg[i] <= 1'b1;
                else if (ctl_bit(drive_ctrl_flat, i, `DSR_CT_WRN_RST))
                    wrn_sticky_reg[i] <= 1'b0;
                if (!ctl_bit(drive_ctrl_flat, i, `DSR_CT_FLD_ID))
                    ident_reg[i] <= 1'b0;
                else if (field_ident_done[i])
                    ident_reg[i] <= 1'b1;
                // No clear exists for calibration flags, only reset drops them
                if (resolver_gain_done[i])
                    gain_reg[i] <= 1'b1;
                if (resolver_balance_done[i] && ctl_bit(drive_ctrl_flat, i, `DSR_CT_CAL_EN)
                    && pin_bit(pin_s2_reg, i, 7))
                    bal_reg[i] <= 1'b1;
            end
        end
    end

    // =========================================
    // Strobe edge capture; pending bit lives for one published scan
    integer j;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strobe_edge_polarity_reg <= {CH{1'b0}};
            str_pend_reg <= {CH{1'b0}};
            strb_prev_reg <= {CH{1'b0}};
            strobe_pos_flat <= {16*CH{1'b0}};
        end else if (clk_en) begin
            for (j = 0; j < CH; j = j + 1) begin
                strb_prev_reg[j] <= pin_bit(pin_s2_reg, j, 8);
                if (pin_bit(pin_s2_reg, j, 8) != strb_prev_reg[j]) begin
                    str_pend_reg[j] <= 1'b1;
                    strobe_edge_polarity_reg[j] <= pin_bit(pin_s2_reg, j, 8);
                    strobe_pos_flat[16*j +: 16] <= resolver_pos_flat[16*j +: 16];
                end else if (scan_strobe && !global_stop) begin
                    str_pend_reg[j] <= 1'b0;
                end
            end
        end
    end

    // =========================================
    // Sync lock; a clean cycle restarts the count, so only back-to-back misses or sync_enabled low drop it
    integer m;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            miss_cnt_reg <= {2*CH{1'b0}};
            lock_reg <= {CH{1'b0}};
        end else if (clk_en) begin
            for (m = 0; m < CH; m = m + 1) begin
                if (!sync_enabled) begin
                    miss_cnt_reg[2*m +: 2] <= 2'h0;
                    lock_reg[m] <= 1'b0;
                end else if (pin_bit(pin_s2_reg, m, 0)) begin
                    if (miss_cnt_reg[2*m +: 2] == `DSR_SYNC_LOSS_MAX - 2'h1)
                        lock_reg[m] <= 1'b0;
                    if (miss_cnt_reg[2*m +: 2] != `DSR_SYNC_LOSS_MAX)
                        miss_cnt_reg[2*m +: 2] <= miss_cnt_reg[2*m +: 2] + 2'h1;
                end else begin
                    miss_cnt_reg[2*m +: 2] <= 2'h0;
                    if (sync_match[m])
                        lock_reg[m] <= 1'b1;
                end
            end
        end
    end

    // =========================================
    // Word assembly, published once per scan
    integer k;
    always @* begin
        st_word_next = st_word_reg;
        io_word_next = io_word_reg;
        for (k = 0; k < CH; k = k + 1) begin
            st_word_next[16*k +: 16] = `DSR_RESET_WORD;
            st_word_next[16*k+`DSR_ST_FLD_ON] = field_reg_active[k]
                && ctl_bit(drive_ctrl_flat, k, `DSR_CT_FLD_RUN);
            st_word_next[16*k+`DSR_ST_FLD_IDC] = ident_reg[k];
            st_word_next[16*k+`DSR_ST_FLD_LIM] = field_loop_limited[k];
            st_word_next[16*k+`DSR_ST_FLT] = flt_sticky_reg[k];
            st_word_next[16*k+`DSR_ST_WRN] = wrn_sticky_reg[k];
            // Order is only meaningful while ready is set
            st_word_next[16*k+`DSR_ST_PH_ORD] = line_phase_order[k];
            st_word_next[16*k+`DSR_ST_LINE_PHASE_READY] = line_phase_ready[k];
            st_word_next[16*k+`DSR_ST_SYNC] = lock_reg[k] && sync_enabled;
            st_word_next[16*k+`DSR_ST_OS] = os_download_done[k];
            io_word_next[16*k +: 16] = `DSR_RESET_WORD;
            io_word_next[16*k+`DSR_IO_RUN] = pin_bit(pin_s2_reg, k, 6);
            io_word_next[16*k+`DSR_IO_CONT] = pin_bit(pin_s2_reg, k, 5);
            io_word_next[16*k+`DSR_IO_AUX2] = pin_bit(pin_s2_reg, k, 4);
            io_word_next[16*k+`DSR_IO_AUX3] = pin_bit(pin_s2_reg, k, 3);
            io_word_next[16*k+`DSR_IO_AUX4] = pin_bit(pin_s2_reg, k, 2);
            io_word_next[16*k+`DSR_IO_AUX5] = pin_bit(pin_s2_reg, k, 1);
            io_word_next[16*k+`DSR_IO_GAN] = gain_reg[k];
            io_word_next[16*k+`DSR_IO_BAL] = bal_reg[k];
            io_word_next[16*k+`DSR_IO_STR] = str_pend_reg[k];
            io_word_next[16*k+`DSR_IO_LVL] = strobe_edge_polarity_reg[k];
        end
    end

    // =========================================
    // Frozen during global stop so software sees the last scan
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_word_reg <= {16*CH{1'b0}};
            io_word_reg <= {16*CH{1'b0}};
        end else if (clk_en && scan_strobe && !global_stop) begin
            st_word_reg <= st_word_next;
            io_word_reg <= io_word_next;
        end
    end

    // =========================================
    // Read port; unmapped addresses return zero
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_en;
            if (!rd_en)
                rd_data <= 16'h0000;
            else case (rd_addr)
                `DSR_STATE_A_OFS: rd_data <= st_word_reg[15:0];
                `DSR_INPUT_A_OFS: rd_data <= io_word_reg[15:0];
                `DSR_STATE_B_OFS: rd_data <= st_word_reg[16*CH-1:16*CH-16];
                `DSR_INPUT_B_OFS: rd_data <= io_word_reg[16*CH-1:16*CH-16];
                default: rd_data <= 16'h0000;
            endcase
        end
    end
endmodule // dsr_readback

// file: sim/dsr_readback_monitor.sv
// Port-level assertions for the status readback block
module dsr_readback_monitor #(
    parameter CH = 2
) (
    input wire clock,
    input wire rstn,
    input wire clk_en,
    input wire scan_strobe,
    input wire global_stop,
    input wire sync_enabled,
    input wire [CH-1:0] ext_strobe,
    input wire rd_en,
    input wire [11:0] rd_addr,
    input wire [15:0] rd_data,
    input wire rd_valid,
    input wire [16*CH-1:0] strobe_pos_flat
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ========================================
    // Address decode
    wire is_state = rd_addr == 12'h0C8 || rd_addr == 12'h4B0;
    wire mapped = is_state || rd_addr == 12'h0C9 || rd_addr == 12'h4B1;
    wire no_pub = global_stop || !scan_strobe;
    // ========================================
    // Read port and word contents
    property p_answer; clk_en && rd_en |=> rd_valid; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_idle; clk_en && !rd_en |=> !rd_valid && rd_data == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("idle read port not zero");
    property p_hold; !clk_en |=> $stable(rd_data) && $stable(rd_valid); endproperty
    a_hold: assert property (p_hold) else $error("output moved while frozen");
    property p_unmap; clk_en && rd_en && !mapped |=> rd_data == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_resv; clk_en && rd_en && is_state |=> (rd_data & 16'h3080) == 16'h0000; endproperty
    a_resv: assert property (p_resv) else $error("undefined state bit set");
    // Two reads with no publish between them must agree
    property p_keep;
        clk_en && rd_en && no_pub ##1 clk_en && rd_en && no_pub && $stable(rd_addr)
            |=> $stable(rd_data);
    endproperty
    a_keep: assert property (p_keep) else $error("word changed without publish");
    property p_sync_off;
        (!sync_enabled && clk_en)[*3] ##0 (scan_strobe && !global_stop)
            ##1 (clk_en && rd_en && is_state) |=> !rd_data[14];
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("lock shown while disabled");
    // Pin path is a few cycles long, so six quiet cycles rule out a capture
    property p_quiet; (clk_en && $stable(ext_strobe))[*6] |=> $stable(strobe_pos_flat); endproperty
    a_quiet: assert property (p_quiet) else $error("capture without strobe edge");
endmodule // dsr_readback_monitor

bind dsr_readback dsr_readback_monitor #(.CH(CH)) mon_u (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .scan_strobe(scan_strobe), .global_stop(global_stop),
    .sync_enabled(sync_enabled), .ext_strobe(ext_strobe), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .strobe_pos_flat(strobe_pos_flat));

// file: sim/dsr_link_model.sv
// Model of the link processor that publishes fresh words once per scan
module dsr_link_model #(
    parameter LAG = 1
) (
    input wire clock,
    input wire rstn,
    input wire scan_req,
    output reg scan_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    integer cnt;
    // One publish pulse per requested scan, after a link lag
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            scan_strobe <= 1'b0;
        end else begin
            scan_strobe <= cnt == 1;
            if (scan_req)
                cnt <= LAG;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule // dsr_link_model

// file: sim/dsr_readback_tb.sv
// Self-checking testbench of the status readback block
module dsr_readback_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Signals
    reg clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, scan_req = 1'b0, global_stop = 1'b0;
    reg sync_enabled = 1'b0, rd_en = 1'b0;
    reg [11:0] rd_addr = 12'h000;
    reg [1:0] f_on = 2'h0, f_id = 2'h0, f_lim = 2'h0, flt = 2'h0, wrn = 2'h0, ph_o = 2'h0;
    reg [1:0] ph_r = 2'h0, os = 2'h0, miss = 2'h0, match = 2'h0, gan = 2'h0, bal = 2'h0;
    reg [1:0] turn = 2'h0, str = 2'h0;
    reg [1:0] pin [0:5];
    reg [31:0] ctrl = 32'h0, pos = 32'h0;
    wire scan_strobe, rd_valid;
    wire [15:0] rd_data;
    wire [31:0] spos;
    integer miscompares = 0, samples_checked = 0, i;
    always #50 clock = ~clock;
    dsr_link_model #(.LAG(3)) link_u (.clock(clock), .rstn(rstn), .scan_req(scan_req),
        .scan_strobe(scan_strobe));
    dsr_readback #(.CH(2)) dut_u (.clock(clock), .rstn(rstn), .clk_en(clk_en),
        .scan_strobe(scan_strobe), .global_stop(global_stop), .field_reg_active(f_on),
        .field_ident_done(f_id), .field_loop_limited(f_lim), .fault_event(flt),
        .warning_event(wrn), .drive_ctrl_flat(ctrl), .line_phase_order(ph_o),
        .line_phase_ready(ph_r), .sync_enabled(sync_enabled), .sync_miss(miss),
        .sync_match(match), .os_download_done(os), .run_permit_input(pin[0]),
        .contactor_feedback(pin[1]), .aux_input_two(pin[2]), .aux_input_three(pin[3]),
        .aux_input_four(pin[4]), .aux_input_five(pin[5]), .resolver_gain_done(gan),
        .resolver_balance_done(bal), .motor_turning(turn), .ext_strobe(str),
        .resolver_pos_flat(pos), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .strobe_pos_flat(spos));
    // ========================================
    // Shared tasks
    task stop_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task step(input integer n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Hold keeps the request up for a back-to-back read
    task rd(input [11:0] a, input [15:0] exp, input bit h = 1'b0);
        rd_en = 1'b1;
        rd_addr = a;
        step(1);
        chk({15'h0, rd_valid}, 16'h0001);
        chk(rd_data, exp);
        // Let an edge pass with the request down so no signal is set twice at once
        if (!h) begin
            rd_en = 1'b0;
            step(1);
        end
    endtask
    task scan;
        integer k;
        scan_req = 1'b1;
        step(1);
        scan_req = 1'b0;
        for (k = 0; k < 8 && scan_strobe !== 1'b1; k = k + 1)
            step(1);
        if (k == 8) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: no publish pulse", $time);
            stop_test;
        end
        step(1);
    endtask
    // ========================================
    // Scenarios
    task t_state;
        {f_on, f_id, f_lim, ph_o, ph_r, os} = {6{2'b01}};
        ctrl[5:4] = 2'b11;
        sync_enabled = 1'b1;
        match = 2'b11;
        step(2);
        match = 2'b00;
        scan;
        rd(12'h0C8, 16'hCC70);
        rd(12'h4B0, 16'h4000);
        ctrl[5:4] = 2'b00;
        ph_o = 2'b00;
        step(2);
        scan;
        rd(12'h0C8, 16'hC840);
        {f_on, f_id, f_lim, ph_o, ph_r, os} = 12'h000;
    endtask
    task t_flt;
        integer j;
        for (j = 0; j < 2; j = j + 1) begin
            {wrn, flt} = j ? 4'b0100 : 4'b0001;
            step(1);
            {wrn, flt} = 4'b0000;
            step(2);
            scan;
            rd(12'h0C8, 16'h4000 | (16'h0100 << j));
            ctrl[8 + j] = 1'b1;
            {wrn, flt} = j ? 4'b0100 : 4'b0001;
            step(2);
            scan;
            rd(12'h0C8, 16'h4000 | (16'h0100 << j));
            {wrn, flt} = 4'b0000;
            step(2);
            scan;
            ctrl[8 + j] = 1'b0;
            rd(12'h0C8, 16'h4000);
        end
    endtask
    task t_sync;
        integer j;
        // Two isolated misses must not add up to a loss of lock
        for (j = 0; j < 2; j = j + 1) begin
            miss = 2'b01;
            step(1);
            miss = 2'b00;
            step(4);
            scan;
            rd(12'h0C8, 16'h4000);
        end
        miss = 2'b01;
        step(2);
        miss = 2'b00;
        step(4);
        scan;
        rd(12'h0C8, 16'h0000);
        rd(12'h4B0, 16'h4000);
        sync_enabled = 1'b0;
        step(3);
        scan;
        rd(12'h4B0, 16'h0000);
    endtask
    task t_io;
        for (i = 0; i < 6; i = i + 1) begin
            pin[i] = 2'b10;
            step(4);
            scan;
            rd(12'h4B1, 16'h0001 << i);
            pin[i] = 2'b00;
        end
        {gan, bal, turn} = 6'h15;
        step(4);
        scan;
        rd(12'h0C9, 16'h0040);
        ctrl[6] = 1'b1;
        step(4);
        scan;
        rd(12'h0C9, 16'h00C0);
    endtask
    task t_str;
        pos[15:0] = 16'h1234;
        str = 2'b01;
        step(6);
        chk(spos[15:0], 16'h1234);
        scan;
        rd(12'h0C9, 16'h03C0);
        scan;
        rd(12'h0C9, 16'h02C0);
        pos[15:0] = 16'h0ABC;
        str = 2'b00;
        step(6);
        chk(spos[15:0], 16'h0ABC);
        chk(spos[31:16], 16'h0000);
        scan;
        rd(12'h0C9, 16'h01C0);
    endtask
    task t_stop;
        global_stop = 1'b1;
        pin[0] = 2'b01;
        step(4);
        scan;
        rd(12'h0C9, 16'h01C0, 1'b1);
        rd(12'h0C9, 16'h01C0);
        clk_en = 1'b0;
        step(2);
        clk_en = 1'b1;
        global_stop = 1'b0;
        scan;
        rd(12'h0C9, 16'h00C1);
    endtask
    initial begin
        for (i = 0; i < 6; i = i + 1)
            pin[i] = 2'b00;
        step(16);
        rstn = 1'b1;
        step(1);
        rd(12'h0C8, 16'h0000);
        rd(12'h4B1, 16'h0000);
        rd(12'h0CA, 16'h0000);
        t_state;
        t_flt;
        t_sync;
        t_io;
        t_str;
        t_stop;
        stop_test;
    end
endmodule // dsr_readback_tb
